//--- design/ccp_pkg.sv
package ccp_pkg;

    // Register indices on the plain register port; printed offset kept for the control register.
    localparam logic [7:0] CTRL_OFFSET      = 8'h17;
    localparam logic [7:0] VALUE_LOW_OFFSET = 8'h15;
    localparam logic [7:0] VALUE_HI_OFFSET  = 8'h16;
    localparam logic [7:0] FLAG_OFFSET      = 8'h0C;
    localparam logic [7:0] ENABLE_OFFSET    = 8'h8C;

    // Field positions.
    localparam int MODE_LSB      = 0;
    localparam int DUTY_LSB      = 4;
    localparam int FLAG_BIT      = 2;
    localparam int OVF_FLAG_BIT  = 0;

    // Reset values.
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] VALUE_RESET = 8'h00;

    // Mode field encodings.
    localparam logic [3:0] MODE_OFF       = 4'h0;
    localparam logic [3:0] MODE_CAP_FALL  = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE  = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MODE_CMP_SET   = 4'h8;
    localparam logic [3:0] MODE_CMP_CLR   = 4'h9;
    localparam logic [3:0] MODE_CMP_SOFT  = 4'hA;
    localparam logic [3:0] MODE_CMP_TRIG  = 4'hB;

    // Prescaler terminal counts.
    localparam logic [3:0] PRE_TERM4  = 4'h3;
    localparam logic [3:0] PRE_TERM16 = 4'hF;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ccp_bus_t;

    typedef struct packed {
        logic       special_trigger;
        logic       start_conversion;
        logic       timer_two_clear;
    } ccp_trig_t;

endpackage : ccp_pkg

//--- design/ccp_unit.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// (R1) Mode field 0000 disables the unit and resets output and prescaler.
// (R2) Modes 0100..0111 capture on falling, rising, 4th rising, 16th rising edge.
// (R3) Compare 1000 drives output high, 1001 low on match; both set the flag.
// (R4) Compare 1010 sets the flag only; pin untouched.
// (R5) Compare 1011 sets the flag and pulses the special trigger.
// (R6) Mode 11xx selects PWM with up to ten-bit duty resolution.
// (R7) Control bits 5:4 hold the two low duty bits in PWM mode.
// (R8) A capture copies the full 16-bit timer one count into the value pair.
// (R9) Capture sets the event flag; only software clears it.
// (R10) A newer capture overwrites the older captured value.
// (R11) Edge detection watches the pin level regardless of pin direction.
// (R12) Software runs timer one synchronously when using capture or compare.
// (R13) Software masks the interrupt and clears the flag around mode changes.
// (R14) Prescaler clears when off, in non-capture modes, and on reset.
// (R15) Switching between capture prescalers keeps the prescaler count.
// (R16) Compare runs continuously; pin action and flag happen together.
// (R17) Writing zero to control forces the output latch low.
// (R18) The special trigger never sets the timer one overflow flag.
// (R19) Software sets pin direction to suit the mode.
// (R20) After timer two equals period: clear timer two, set pin unless duty zero, latch duty.
// (R21) Pin clears when latched duty equals timer two with two extra low bits.
// (R22) In PWM mode the high value byte is read-only, the duty double buffer.
// (R23) Duty longer than the period never clears the pin.
// (R24) The pin is synchronised before edge detection.
// (R25) A compare match acts once per timer one count value.
module ccp_unit
    import ccp_pkg::*;
(
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        clk_en,
    // Register port.
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Timers.
    input  wire logic [15:0] timer_one_count,
    input  wire logic [7:0]  timer_two_count,
    input  wire logic [7:0]  timer_two_period,
    input  wire logic        timer_two_tick,
    input  wire logic [1:0]  timer_two_sub,
    input  wire logic        adc_enabled,
    // Pin.
    input  wire logic        capture_compare_pin_in,
    output logic             compare_out,
    // Events.
    output logic             unit_event_flag,
    output logic             unit_irq,
    output logic             special_trigger,
    output logic             start_conversion,
    output logic             timer_two_clear,
    output logic             timer_one_overflow_flag
);

    typedef enum logic [3:0] {
        ST_OFF     = 4'b0001,
        ST_CAPTURE = 4'b0010,
        ST_COMPARE = 4'b0100,
        ST_PWM     = 4'b1000
    } ccp_state_t;

    ccp_bus_t   bus;
    ccp_trig_t  trig_reg, trig_next;
    ccp_state_t state;

    logic [7:0]  ctrl_reg, ctrl_next;
    logic [7:0]  vlow_reg, vlow_next;
    logic [7:0]  vhigh_reg, vhigh_next;
    logic [1:0]  duty_lsb_reg, duty_lsb_next;
    logic        flag_reg, flag_next;
    logic        irq_en_reg, irq_en_next;
    logic        out_reg, out_next;
    logic [3:0]  pre_reg, pre_next;
    logic        sync1_reg, sync2_reg, prev_reg;
    logic        prev_next;
    logic        matched_reg, matched_next;
    logic [7:0]  rdata_reg, rdata_next;
    logic [3:0]  mode;
    logic        rise, fall, cap_event, match, fire;
    logic        at_period_reg, at_period_next;
    logic [9:0]  duty_active;
    logic [9:0]  pwm_pos_next;

    assign bus  = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign mode = ctrl_reg[MODE_LSB +: 4];

    always_comb begin
        case (1'b1)
            (mode == MODE_OFF):    state = ST_OFF;
            (mode[3:2] == 2'b01):  state = ST_CAPTURE;
            (mode[3:2] == 2'b10):  state = ST_COMPARE;
            (mode[3:2] == 2'b11):  state = ST_PWM;
            default:               state = ST_OFF;
        endcase
    end

    // The pin is read as a level whatever its direction is. [R11] [R24]
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else if (clk_en) begin
            sync1_reg <= capture_compare_pin_in;
            sync2_reg <= sync1_reg;
        end
    end

    assign rise  = sync2_reg & ~prev_reg;
    assign fall  = ~sync2_reg & prev_reg;
    assign match = (state == ST_COMPARE) && ({vhigh_reg, vlow_reg} == timer_one_count);
    assign fire  = match && !matched_reg; // [R25]
    assign duty_active = {vhigh_reg, duty_lsb_reg};
    // The pin is a register, so it must drop on the edge that brings the position to the duty.
    assign pwm_pos_next = {timer_two_count, timer_two_sub} + 10'h001;

    always_comb begin
        cap_event = 1'b0;
        pre_next  = pre_reg;
        if (state != ST_CAPTURE) begin
            pre_next = 4'h0; // [R14]
        end else begin
            case (mode)
                MODE_CAP_FALL:   cap_event = fall; // [R2]
                MODE_CAP_RISE:   cap_event = rise;
                MODE_CAP_RISE4: begin
                    if (rise) begin
                        cap_event = (pre_reg[1:0] == PRE_TERM4[1:0]);
                        pre_next  = pre_reg + 4'h1; // [R15]
                    end
                end
                MODE_CAP_RISE16: begin
                    if (rise) begin
                        cap_event = (pre_reg == PRE_TERM16);
                        pre_next  = pre_reg + 4'h1;
                    end
                end
                default: cap_event = 1'b0;
            endcase
        end
    end

    always_comb begin
        ctrl_next      = ctrl_reg;
        vlow_next      = vlow_reg;
        vhigh_next     = vhigh_reg;
        duty_lsb_next  = duty_lsb_reg;
        flag_next      = flag_reg;
        irq_en_next    = irq_en_reg;
        out_next       = out_reg;
        prev_next      = sync2_reg;
        matched_next   = match;
        trig_next      = '0;
        rdata_next     = 8'h00;
        at_period_next = (timer_two_count == timer_two_period);
        if (bus.wr) begin
            case (bus.addr)
                CTRL_OFFSET:      ctrl_next = {2'b00, bus.wdata[5:0]};
                VALUE_LOW_OFFSET: vlow_next = bus.wdata;
                VALUE_HI_OFFSET: begin
                    if (state != ST_PWM) begin
                        vhigh_next = bus.wdata; // [R22]
                    end
                end
                FLAG_OFFSET:      flag_next = bus.wdata[FLAG_BIT];
                ENABLE_OFFSET:    irq_en_next = bus.wdata[FLAG_BIT];
                default:          ctrl_next = ctrl_reg;
            endcase
            if (bus.addr == CTRL_OFFSET && bus.wdata[5:0] == 6'h00) begin
                out_next = 1'b0; // [R1] [R17]
            end
        end
        if (bus.rd) begin
            case (bus.addr)
                CTRL_OFFSET:      rdata_next = ctrl_reg;
                VALUE_LOW_OFFSET: rdata_next = vlow_reg;
                VALUE_HI_OFFSET:  rdata_next = vhigh_reg;
                FLAG_OFFSET:      rdata_next = 8'(flag_reg) << FLAG_BIT;
                ENABLE_OFFSET:    rdata_next = 8'(irq_en_reg) << FLAG_BIT;
                default:          rdata_next = 8'h00;
            endcase
        end
        case (state)
            ST_OFF: out_next = 1'b0; // [R1]
            ST_CAPTURE: begin
                if (cap_event) begin
                    {vhigh_next, vlow_next} = timer_one_count; // [R8] [R10]
                    flag_next = 1'b1; // [R9]
                end
            end
            ST_COMPARE: begin
                if (fire) begin
                    flag_next = 1'b1; // [R16]
                    case (mode)
                        MODE_CMP_SET:  out_next = 1'b1; // [R3]
                        MODE_CMP_CLR:  out_next = 1'b0;
                        MODE_CMP_SOFT: out_next = out_reg; // [R4]
                        MODE_CMP_TRIG: begin
                            trig_next.special_trigger  = 1'b1; // [R5]
                            trig_next.start_conversion = adc_enabled;
                        end
                        default:       out_next = out_reg;
                    endcase
                end
            end
            ST_PWM: begin
                // Duty is only taken at period end, so mid-period writes cannot glitch.
                if (timer_two_tick && at_period_reg) begin
                    trig_next.timer_two_clear = 1'b1; // [R20]
                    vhigh_next    = vlow_reg; // [R7] [R22]
                    duty_lsb_next = ctrl_reg[DUTY_LSB +: 2];
                    out_next      = ({vlow_reg, ctrl_reg[DUTY_LSB +: 2]} != 10'h000);
                end else if (duty_active == pwm_pos_next) begin
                    out_next = 1'b0; // [R6] [R21] [R23]
                end
            end
            default: out_next = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg      <= CTRL_RESET;
            vlow_reg      <= VALUE_RESET;
            vhigh_reg     <= VALUE_RESET;
            duty_lsb_reg  <= 2'b00;
            flag_reg      <= 1'b0;
            irq_en_reg    <= 1'b0;
            out_reg       <= 1'b0;
            pre_reg       <= 4'h0; // [R14]
            prev_reg      <= 1'b0;
            matched_reg   <= 1'b0;
            trig_reg      <= '0;
            rdata_reg     <= 8'h00;
            at_period_reg <= 1'b0;
        end else if (clk_en) begin
            ctrl_reg      <= ctrl_next;
            vlow_reg      <= vlow_next;
            vhigh_reg     <= vhigh_next;
            duty_lsb_reg  <= duty_lsb_next;
            flag_reg      <= flag_next;
            irq_en_reg    <= irq_en_next;
            out_reg       <= out_next;
            pre_reg       <= pre_next;
            prev_reg      <= prev_next;
            matched_reg   <= matched_next;
            trig_reg      <= trig_next;
            rdata_reg     <= rdata_next;
            at_period_reg <= at_period_next;
        end
    end

    assign reg_rdata               = rdata_reg;
    assign compare_out             = out_reg;
    assign unit_event_flag         = flag_reg;
    assign unit_irq                = flag_reg & irq_en_reg; // [R4]
    assign special_trigger         = trig_reg.special_trigger;
    assign start_conversion        = trig_reg.start_conversion;
    assign timer_two_clear         = trig_reg.timer_two_clear;
    assign timer_one_overflow_flag = 1'b0; // [R18]

    a_cap_sets_flag: assert property (@(posedge clock) disable iff (!arst_n) // [R9]
        clk_en && state == ST_CAPTURE && cap_event |=> unit_event_flag)
        else $error("capture did not set flag");
    a_cap_snapshot: assert property (@(posedge clock) disable iff (!arst_n) // [R8]
        clk_en && state == ST_CAPTURE && cap_event && !bus.wr
        |=> {vhigh_reg, vlow_reg} == $past(timer_one_count))
        else $error("capture value wrong");
    a_off_out_low: assert property (@(posedge clock) disable iff (!arst_n) // [R1]
        clk_en && state == ST_OFF |=> !compare_out)
        else $error("output not low when off");
    a_pre_cleared: assert property (@(posedge clock) disable iff (!arst_n) // [R14]
        clk_en && state != ST_CAPTURE |=> pre_reg == 4'h0)
        else $error("prescaler not cleared");
    a_cmp_set_high: assert property (@(posedge clock) disable iff (!arst_n) // [R3]
        clk_en && fire && mode == MODE_CMP_SET && !bus.wr |=> compare_out && unit_event_flag)
        else $error("compare set failed");
    a_cmp_clr_low: assert property (@(posedge clock) disable iff (!arst_n) // [R3]
        clk_en && fire && mode == MODE_CMP_CLR && !bus.wr |=> !compare_out && unit_event_flag)
        else $error("compare clear failed");
    a_trig_pulse: assert property (@(posedge clock) disable iff (!arst_n) // [R5]
        clk_en && fire && mode == MODE_CMP_TRIG |=> special_trigger ##1 !special_trigger[*1])
        else $error("trigger not one pulse");
    a_match_once: assert property (@(posedge clock) disable iff (!arst_n) // [R25]
        clk_en && special_trigger && $stable(timer_one_count) && clk_en |=> !special_trigger)
        else $error("repeat match action");
    a_ovf_never: assert property (@(posedge clock) disable iff (!arst_n) // [R18]
        special_trigger |-> !timer_one_overflow_flag)
        else $error("overflow flag set");
    a_pwm_period: assert property (@(posedge clock) disable iff (!arst_n) // [R20]
        clk_en && state == ST_PWM && timer_two_tick && at_period_reg && !bus.wr
        |=> timer_two_clear && vhigh_reg == $past(vlow_reg))
        else $error("pwm period end wrong");

    c_capture: cover property (@(posedge clock) state == ST_CAPTURE && cap_event);
    c_compare: cover property (@(posedge clock) fire && mode == MODE_CMP_SET);
    c_trigger: cover property (@(posedge clock) special_trigger);
    c_pwm:     cover property (@(posedge clock) state == ST_PWM && timer_two_clear);

endmodule : ccp_unit

//--- testbench/ccp_pin_model.sv
`timescale 1ns/1ps
// Source on the unit's pin; it moves only after a clock edge, as a synchronous driver would.
module ccp_pin_model (
    // Clock.
    input  wire logic clock,
    // Requested level.
    input  wire logic level_req,
    // Pin.
    output logic      pin
);
    initial pin = 1'b0;
    // The level reaches the unit whatever the pin direction is.
    always @(posedge clock) pin <= level_req;
endmodule : ccp_pin_model

//--- testbench/ccp_unit_tb.sv
`timescale 1ns/1ps
module ccp_unit_tb;
    import ccp_pkg::*;
    logic        clock = 1'b0;
    logic        arst_n = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        lvl = 1'b0;
    logic        irq_en = 1'b0;
    logic        clk_en = 1'b1;
    logic        adc_en = 1'b1;
    logic [1:0]  t2_sub = 2'h0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  t2_cnt = 8'h00;
    logic [15:0] t1 = 16'h0000;
    wire  [7:0]  rdata;
    wire         pin, cmp_out, flag, irq, trig, conv, t2_clr, ovf;
    wire         t2_tick = (t2_sub == 2'h3);
    int          fail_count = 0;
    int          total_checks = 0;
    int          trig_n = 0;
    int          conv_n = 0;

    ccp_unit uut (.clock(clock), .arst_n(arst_n), .clk_en(clk_en), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
        .timer_one_count(t1), .timer_two_count(t2_cnt), .timer_two_period(8'h03),
        .timer_two_tick(t2_tick), .timer_two_sub(t2_sub), .adc_enabled(adc_en),
        .capture_compare_pin_in(pin), .compare_out(cmp_out), .unit_event_flag(flag),
        .unit_irq(irq), .special_trigger(trig), .start_conversion(conv),
        .timer_two_clear(t2_clr), .timer_one_overflow_flag(ovf));
    ccp_pin_model pm (.clock(clock), .level_req(lvl), .pin(pin));

    always #25 clock = ~clock;
    // Timer two stays synchronous to the clock, so its count is stable at every edge.
    always @(posedge clock) begin
        t2_sub <= t2_sub + 2'h1;
        if (t2_tick) t2_cnt <= (t2_cnt == 8'h03) ? 8'h00 : t2_cnt + 8'h01;
        if (trig === 1'b1) trig_n++;
        if (conv === 1'b1) conv_n++;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask : idle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
        @(posedge clock);
        addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(what, {8'h00, e}, {8'h00, rdata});
    endtask : rd
    task automatic pin_to(input logic v);
        lvl <= v;
        idle(6);
    endtask : pin_to
    task automatic cap(input logic [3:0] m, input int n, input logic [15:0] ts);
        wr(CTRL_OFFSET, 8'h00);
        wr(CTRL_OFFSET, {4'h0, m});
        wr(FLAG_OFFSET, 8'h00);
        t1 <= ts;
        for (int i = 1; i <= n; i++) begin
            pin_to(1'b1);
            pin_to(1'b0);
            chk("capture_flag", 16'(i == n), {15'h0, flag});
        end
        rd(VALUE_LOW_OFFSET, ts[7:0], "value_low");
        rd(VALUE_HI_OFFSET, ts[15:8], "value_high");
    endtask : cap
    task automatic cmp(input logic [3:0] m, input logic e);
        t1 <= 16'h0000;
        wr(CTRL_OFFSET, {4'h0, m});
        wr(FLAG_OFFSET, 8'h00);
        t1 <= 16'h0140;
        idle(3);
        chk("compare_out", {15'h0, e}, {15'h0, cmp_out});
        chk("compare_flag", 16'h0001, {15'h0, flag});
        chk("irq", {15'h0, irq_en}, {15'h0, irq});
        wr(FLAG_OFFSET, 8'h00);
        idle(3);
        chk("flag_once", 16'h0000, {15'h0, flag});
    endtask : cmp
    task automatic pwm(input logic [7:0] lo, input logic [7:0] c, input int e);
        int hi;
        int nc;
        hi = 0;
        nc = 0;
        wr(VALUE_LOW_OFFSET, lo);
        wr(CTRL_OFFSET, c);
        idle(40);
        repeat (64) begin
            @(posedge clock);
            if (cmp_out === 1'b1) hi++;
            if (t2_clr === 1'b1) nc++;
        end
        chk("pwm_high", e[15:0], hi[15:0]);
        chk("period_clears", 16'h0004, nc[15:0]);
    endtask : pwm

    initial begin
        idle(5);
        arst_n <= 1'b1;
        rd(CTRL_OFFSET, CTRL_RESET, "control_reset");
        rd(VALUE_LOW_OFFSET, VALUE_RESET, "value_low_reset");
        rd(8'h40, 8'h00, "unmapped");
        clk_en <= 1'b0;
        wr(VALUE_LOW_OFFSET, 8'hA5);
        clk_en <= 1'b1;
        rd(VALUE_LOW_OFFSET, VALUE_RESET, "frozen_write");
        chk("out_reset", 16'h0000, {15'h0, cmp_out});
        $display("test reset done");
        cap(MODE_CAP_FALL, 1, 16'h1234);
        cap(MODE_CAP_RISE, 1, 16'h5678);
        t1 <= 16'h2468;
        pin_to(1'b1);
        t1 <= 16'h1357;
        pin_to(1'b0);
        pin_to(1'b1);
        rd(VALUE_LOW_OFFSET, 8'h57, "overwrite");
        pin_to(1'b0);
        cap(MODE_CAP_RISE4, 4, 16'h9ABC);
        cap(MODE_CAP_RISE16, 16, 16'hDEF0);
        for (int i = 0; i < 2; i++) pin_to(1'b1);
        for (int i = 0; i < 2; i++) begin
            pin_to(1'b1);
            pin_to(1'b0);
        end
        wr(CTRL_OFFSET, {4'h0, MODE_CAP_RISE4});
        wr(FLAG_OFFSET, 8'h00);
        for (int i = 0; i < 2; i++) begin
            pin_to(1'b1);
            pin_to(1'b0);
        end
        chk("partial_prescale", 16'h0001, {15'h0, flag});
        $display("test capture done");
        wr(VALUE_LOW_OFFSET, 8'h40);
        wr(VALUE_HI_OFFSET, 8'h01);
        cmp(MODE_CMP_SET, 1'b1);
        cmp(MODE_CMP_CLR, 1'b0);
        cmp(MODE_CMP_SET, 1'b1);
        irq_en = 1'b1;
        wr(ENABLE_OFFSET, 8'h04);
        cmp(MODE_CMP_SOFT, 1'b1);
        irq_en = 1'b0;
        wr(ENABLE_OFFSET, 8'h00);
        trig_n = 0;
        conv_n = 0;
        cmp(MODE_CMP_TRIG, 1'b1);
        chk("trigger_count", 16'h0001, trig_n[15:0]);
        chk("conversion_count", 16'h0001, conv_n[15:0]);
        chk("overflow_flag", 16'h0000, {15'h0, ovf});
        adc_en <= 1'b0;
        trig_n = 0;
        conv_n = 0;
        cmp(MODE_CMP_TRIG, 1'b1);
        chk("trigger_count_adc_off", 16'h0001, trig_n[15:0]);
        chk("conversion_adc_off", 16'h0000, conv_n[15:0]);
        wr(CTRL_OFFSET, 8'h00);
        idle(2);
        chk("out_forced_low", 16'h0000, {15'h0, cmp_out});
        $display("test compare done");
        pwm(8'h01, 8'h0C, 16);
        wr(VALUE_HI_OFFSET, 8'h55);
        rd(VALUE_HI_OFFSET, 8'h01, "duty_buffer");
        pwm(8'h01, 8'h2C, 24);
        pwm(8'h00, 8'h0C, 0);
        pwm(8'hFF, 8'h0C, 64);
        $display("test pwm done");
        final_report();
    end
endmodule : ccp_unit_tb
